// ==== core/idr_map.svh ====
// Constants for the identification ROM access sequencer.
`ifndef IDR_MAP_SVH
`define IDR_MAP_SVH
// ****************************************
// Address map and field layout
// ****************************************
`define IDR_BASE_ADDR 32'h70000000
`define IDR_RANGE_MASK 32'hfff00000
`define IDR_NIB_W 4
// ****************************************
// Timing
// ****************************************
`define IDR_CLK_MHZ 20
`define IDR_RECALL_MIN_US 200
`define IDR_RECALL_MIN_CYC (`IDR_RECALL_MIN_US * `IDR_CLK_MHZ)
`define IDR_ACCESS_MIN_US 2
`define IDR_ACCESS_MIN_CYC (`IDR_ACCESS_MIN_US * `IDR_CLK_MHZ)
`endif

// ==== core/idr_pkg.sv ====
// Types shared by the identification ROM access sequencer.
package idr_pkg;
  // Phases of the recall pulse watcher.
  typedef enum logic [1:0] {IDR_WAIT_LOW, IDR_FIRST_HIGH, IDR_MID_LOW, IDR_ARMED} idr_rcl_e;
endpackage : idr_pkg

// ==== core/idr_sync_counter.sv ====
// Saturating cycle counter that measures how long a level has held.
`timescale 1ns/100ps
`default_nettype none
module idr_sync_counter #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Restart input that clears the count.
  input wire logic clear_i,
  output logic [W-1:0] count_o
);
  import idr_pkg::*;
  // Whole state of the counter, registered in one place.
  typedef struct packed {
    logic [W-1:0] count;
  } idr_cnt_s;
  idr_cnt_s st, next_st;

  // Counts up while not cleared and stops at all ones so it never wraps.
  always_comb begin
    next_st = st;
    if (clear_i) begin
      next_st.count = '0;
    end else if (st.count != {W{1'b1}}) begin
      next_st.count = W'(st.count + 1'b1);
    end
  end

  // Saturation keeps a very long level from aliasing back to a short one.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.count;
endmodule : idr_sync_counter
`default_nettype wire

// ==== core/idr_rom_seq.sv ====
// Module-side decode, recall detection and sequential data source for the ID ROM.
`timescale 1ns/100ps
`default_nettype none
`include "idr_map.svh"
module idr_rom_seq #(
  parameter int ADDR_W = 32,
  parameter int DEPTH = 64,
  parameter bit NIBBLE_MODE = 1'b1,
  parameter logic [3:0] ROM_FILL = 4'h5
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Processor local bus.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic local_strobe_primary_n_i,
  input wire logic rd_wr_n_i,
  input wire logic [3:0] wdata_i,
  // Timer pin used as recall and enable.
  input wire logic rom_enable_recall_line_i,
  // Read data and board controls.
  output logic [31:0] rdata_o,
  output logic rom_select_o,
  output logic other_dev_disable_o,
  output logic recall_pulse_o,
  output logic rom_write_en_o,
  output logic ready_o
);
  import idr_pkg::*;
  localparam int CW = 16;
  localparam int IW = $clog2(DEPTH);
  localparam logic [CW-1:0] RCL_CYC = CW'(`IDR_RECALL_MIN_CYC);
  localparam logic [CW-1:0] ACC_CYC = CW'(`IDR_ACCESS_MIN_CYC);
  // The gap counter reads one less than the edges since the last start, so this is a full spacing.
  localparam logic [CW-1:0] ACC_LAST = CW'(`IDR_ACCESS_MIN_CYC - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    idr_rcl_e rcl;
    logic line_d;
    logic strobe_d;
    logic [IW-1:0] idx;
    logic [31:0] rdata;
    logic sel;
    logic dis;
    logic pulse;
    logic wen;
    logic rdy;
    logic [DEPTH-1:0][3:0] ram;
  } idr_state_s;
  idr_state_s st, next_st;
  logic [CW-1:0] lvl_cnt;
  logic [CW-1:0] gap_cnt;
  logic hit, start;
  logic recall_now;

  // Level-duration counter restarts on every recall line edge.
  idr_sync_counter #(.W(CW)) u_lvl (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(rom_enable_recall_line_i != st.line_d),
    .count_o(lvl_cnt)
  );
  // Spacing counter restarts at each accepted access start.
  idr_sync_counter #(.W(CW)) u_gap (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(start),
    .count_o(gap_cnt)
  );

  // Decode: primary strobe, ROM range, and recall line high only.
  assign hit = !local_strobe_primary_n_i && ((addr_i & `IDR_RANGE_MASK) == (`IDR_BASE_ADDR & `IDR_RANGE_MASK))
    && rom_enable_recall_line_i;
  assign start = hit && st.strobe_d;
  // Final rise of the recall shape; it must win over an access in the same cycle.
  assign recall_now = (st.rcl == IDR_MID_LOW) && rom_enable_recall_line_i;

  // Next-state logic for recall tracking, address stepping and read data.
  always_comb begin
    next_st = st;
    next_st.line_d = rom_enable_recall_line_i;
    next_st.strobe_d = !hit;
    next_st.pulse = 1'b0;
    next_st.sel = hit;
    next_st.dis = rom_enable_recall_line_i;
    next_st.wen = hit && !rd_wr_n_i;
    // Recall shape: low of the minimum width, then high and low of any width, then high.
    case (st.rcl)
      IDR_WAIT_LOW: begin
        if (rom_enable_recall_line_i && !st.line_d && lvl_cnt >= RCL_CYC) begin
          next_st.rcl = IDR_FIRST_HIGH;
        end
      end
      IDR_FIRST_HIGH: begin
        if (!rom_enable_recall_line_i) begin
          next_st.rcl = IDR_MID_LOW;
        end
      end
      IDR_MID_LOW: begin
        if (rom_enable_recall_line_i) begin
          next_st.rcl = IDR_ARMED;
          next_st.pulse = 1'b1;
          next_st.idx = '0;
        end
      end
      default: begin
        if (!rom_enable_recall_line_i && lvl_cnt >= RCL_CYC) begin
          next_st.rcl = IDR_WAIT_LOW;
        end
      end
    endcase
    // Slow-ROM accommodation: hold ready low until the spacing has run out.
    next_st.rdy = hit && gap_cnt >= ACC_LAST;
    if (start) begin
      next_st.rdata = 32'h0;
      if (NIBBLE_MODE) begin
        next_st.rdata[3:0] = st.ram[st.idx];
      end else begin
        next_st.rdata[0] = st.ram[st.idx][0];
      end
      if (!rd_wr_n_i) begin
        next_st.ram[st.idx] = wdata_i;
      end
      next_st.idx = recall_now ? '0 : IW'(st.idx + 1'b1);
    end
  end

  // Single register bank; ROM contents start from a fill value.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{rcl: IDR_WAIT_LOW, strobe_d: 1'b1, ram: {DEPTH{ROM_FILL}}, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rom_select_o = st.sel;
  assign other_dev_disable_o = st.dis;
  assign recall_pulse_o = st.pulse;
  assign rom_write_en_o = st.wen;
  assign ready_o = st.rdy;

  // ****************************************
  // Checks
  // ****************************************
  property p_no_sel_low;
    @(posedge clk_i) disable iff (!rstn_i) !rom_enable_recall_line_i |=> !rom_select_o;
  endproperty
  a_no_sel_low: assert property (p_no_sel_low) else $error("ROM selected with recall line low");
  property p_strobe_only;
    @(posedge clk_i) disable iff (!rstn_i) local_strobe_primary_n_i |=> !rom_select_o;
  endproperty
  a_strobe_only: assert property (p_strobe_only) else $error("ROM selected without primary strobe");
  property p_disable;
    @(posedge clk_i) disable iff (!rstn_i) rom_enable_recall_line_i |=> other_dev_disable_o;
  endproperty
  a_disable: assert property (p_disable) else $error("Other devices not disabled");
  property p_wen_gate;
    @(posedge clk_i) disable iff (!rstn_i) rom_write_en_o |-> $past(rom_enable_recall_line_i);
  endproperty
  a_wen_gate: assert property (p_wen_gate) else $error("Write enabled outside recall high");
  property p_recall_idx;
    @(posedge clk_i) disable iff (!rstn_i) recall_pulse_o |-> st.idx == '0 && st.rcl == IDR_ARMED;
  endproperty
  a_recall_idx: assert property (p_recall_idx) else $error("Recall did not reset address");
  sequence s_mid_low;
    st.rcl == IDR_MID_LOW && rom_enable_recall_line_i;
  endsequence
  property p_recall;
    @(posedge clk_i) disable iff (!rstn_i) s_mid_low |=> recall_pulse_o ##1 !recall_pulse_o;
  endproperty
  a_recall: assert property (p_recall) else $error("Recall pulse missing");
  property p_upper_zero;
    @(posedge clk_i) disable iff (!rstn_i) rdata_o[31:4] == 28'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Upper read bits not zero");
  property p_step;
    @(posedge clk_i) disable iff (!rstn_i) start && !recall_now |=> st.idx == IW'($past(st.idx) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("Address did not step by one");
  property p_ready_gap;
    @(posedge clk_i) disable iff (!rstn_i) ready_o |-> $past(gap_cnt) >= ACC_LAST;
  endproperty
  a_ready_gap: assert property (p_ready_gap) else $error("Ready before spacing elapsed");

  // Accepted accesses: the word and the decode follow one edge after the start.
  sequence s_start;
    start;
  endsequence
  property p_start_sel;
    @(posedge clk_i) disable iff (!rstn_i) s_start |=> rom_select_o;
  endproperty
  a_start_sel: assert property (p_start_sel) else $error("Accepted access not selected");
  property p_data_nib;
    @(posedge clk_i) disable iff (!rstn_i) s_start |=> rdata_o[3:0] ==
      (NIBBLE_MODE ? $past(st.ram[st.idx]) : {3'b000, $past(st.ram[st.idx][0])});
  endproperty
  a_data_nib: assert property (p_data_nib) else $error("Read word does not carry the ROM bits");
  // The word stands until the next accepted access, so a slow reader still sees it.
  property p_rdata_hold;
    @(posedge clk_i) disable iff (!rstn_i) !start |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read word changed without an access");
  // Refused cycles and stray strobes must leave the sequential index alone.
  property p_idx_hold;
    @(posedge clk_i) disable iff (!rstn_i) !start && !recall_now |=> st.idx == $past(st.idx);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("Index moved without an access");
  // Write enable and ready are only ever qualifications of a live selection.
  property p_wen_sel;
    @(posedge clk_i) disable iff (!rstn_i) rom_write_en_o |-> rom_select_o;
  endproperty
  a_wen_sel: assert property (p_wen_sel) else $error("Write enable without selection");
  property p_rdy_sel;
    @(posedge clk_i) disable iff (!rstn_i) ready_o |-> rom_select_o;
  endproperty
  a_rdy_sel: assert property (p_rdy_sel) else $error("Ready without selection");
  // Other devices on the primary strobe are released as soon as the line drops.
  property p_dis_low;
    @(posedge clk_i) disable iff (!rstn_i) !rom_enable_recall_line_i |=> !other_dev_disable_o;
  endproperty
  a_dis_low: assert property (p_dis_low) else $error("Other devices held off with line low");
  // The recall strobe is a single cycle and leaves the watcher armed.
  property p_pulse_one;
    @(posedge clk_i) disable iff (!rstn_i) recall_pulse_o |=> !recall_pulse_o;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("Recall pulse longer than one cycle");
  property p_armed;
    @(posedge clk_i) disable iff (!rstn_i) s_mid_low |=> st.rcl == IDR_ARMED;
  endproperty
  a_armed: assert property (p_armed) else $error("Recall watcher not armed after sequence");
endmodule : idr_rom_seq
`default_nettype wire

// ==== tb/idr_reader.sv ====
// Reader model: recall sequence and ROM bus cycles.
`timescale 1ns/100ps
`default_nettype none
module idr_reader (
  // Clock and answers.
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [31:0] rdata_i,
  // Bus and recall line.
  output logic [31:0] addr_o,
  output logic strobe_n_o,
  output logic rd_wr_n_o,
  output logic line_o
);
  logic [31:0] next_addr;
  // Idle bus: strobe high, line parked low.
  initial begin
    addr_o = 32'h0;
    strobe_n_o = 1'b1;
    rd_wr_n_o = 1'b1;
    line_o = 1'b0;
    next_addr = 32'h70000000;
  end
  // Low, high, low, then high for the whole access phase.
  task automatic recall();
    repeat (4000) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (4000) @(posedge clk_i);
    line_o <= 1'b0;
    repeat (4000) @(posedge clk_i);
    line_o <= 1'b1;
    next_addr = 32'h70000000;
  endtask : recall
  // One read; strobe held until ready is seen high.
  task automatic read(output logic [31:0] w, output int waited);
    repeat (40) @(posedge clk_i);
    addr_o <= next_addr;
    strobe_n_o <= 1'b0;
    rd_wr_n_o <= 1'b1;
    waited = 0;
    // Ready and data are taken at the rising edge that samples ready high.
    do begin
      @(posedge clk_i);
      waited++;
    end while (ready_i !== 1'b1 && waited < 100);
    w = rdata_i;
    strobe_n_o <= 1'b1;
    next_addr++;
  endtask : read
  // Spaced cycle; ROM-range cycles keep the ascending order.
  task automatic drive(input logic [31:0] a, input logic s, input logic r);
    repeat (40) @(posedge clk_i);
    addr_o <= (a[31:20] == 12'h700) ? next_addr : a;
    if (a[31:20] == 12'h700 && !s) begin
      next_addr++;
    end
    strobe_n_o <= s;
    rd_wr_n_o <= r;
    // One sampled cycle, then the strobe is released so each call is its own access.
    @(posedge clk_i);
    strobe_n_o <= 1'b1;
  endtask : drive
endmodule : idr_reader
`default_nettype wire

// ==== tb/test_id_rom_access_sequencer.sv ====
// Self-checking bench for the ID ROM access sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "idr_map.svh"
module test_id_rom_access_sequencer;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] wdata = 4'h0;
  logic [31:0] addr, rdata, w, a;
  logic stb_n, rw, line, sel, dis, pulse, wen, rdy, s, r;
  int miscompares = 0;
  int tests_run = 0;
  int seed = int'(32'haacd088b);
  int waited;
  localparam logic [3:0] FILL = 4'h5;
  // 20 MHz clock.
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  idr_rom_seq #(.ROM_FILL(FILL)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .local_strobe_primary_n_i(stb_n),
    .rd_wr_n_i(rw), .wdata_i(wdata), .rom_enable_recall_line_i(line), .rdata_o(rdata),
    .rom_select_o(sel), .other_dev_disable_o(dis), .recall_pulse_o(pulse), .rom_write_en_o(wen),
    .ready_o(rdy));
  idr_reader rd (.clk_i(clk_i), .ready_i(rdy), .rdata_i(rdata), .addr_o(addr), .strobe_n_o(stb_n),
    .rd_wr_n_o(rw), .line_o(line));
  // Decode hit expected from one cycle of bus state.
  function automatic logic hit(logic [31:0] x, logic sn, logic l);
    return !sn && ((x & `IDR_RANGE_MASK) == `IDR_BASE_ADDR) && l;
  endfunction : hit
  task automatic chk_b(string n, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask : chk_b
  task automatic chk_w(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk_w
  task automatic close_out();
    $display("compares %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // One spaced cycle, then the registered decode is judged.
  task automatic poke(logic [31:0] x, logic sn, logic rn);
    @(posedge clk_i);
    wdata <= 4'($random(seed));
    rd.drive(x, sn, rn);
    @(negedge clk_i);
    chk_b("select", hit(x, sn, line), sel);
    chk_b("write_en", hit(x, sn, line) && !rn, wen);
    chk_b("disable", line, dis);
  endtask : poke
  // Stray cycles, recall, paced reads, then random traffic.
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    poke(32'h70000000, 1'b0, 1'b1);
    poke(32'h70000004, 1'b0, 1'b0);
    rd.recall();
    waited = 0;
    while (pulse !== 1'b1 && waited < 5) begin
      @(negedge clk_i);
      waited++;
    end
    chk_b("recall_pulse", 1'b1, pulse);
    for (int i = 0; i < 2; i++) begin
      rd.read(w, waited);
      if (waited >= 100) begin
        miscompares++;
        close_out();
      end
      chk_w("rdata", {28'h0, FILL}, w);
      chk_w("rdata_id", {28'h0, FILL}, w & 32'hf);
      chk_b("ready_wait", 1'b1, waited == 2);
    end
    for (int i = 0; i < 100; i++) begin
      a = $random(seed);
      if (a[0]) a[31:20] = 12'h700;
      s = 1'($random(seed));
      r = 1'($random(seed));
      poke(a, s, r);
    end
    close_out();
  end
endmodule : test_id_rom_access_sequencer
`default_nettype wire
